// *** codec_ctl_pkg.sv ***
`default_nettype none
package codec_ctl_pkg;
   // register file size: addresses 00h..4fh
   localparam int unsigned REG_COUNT = 80;
   localparam logic [6:0] ADDR_LAST = 7'h4f;
   localparam logic [6:0] ADDR_FIRST = 7'h00;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   // unreadable addresses answer with this byte
   localparam logic [7:0] UNDEF_READ_VAL = 8'h00;
   // readable windows
   localparam logic [6:0] RD_LO_END = 7'h11;
   localparam logic [6:0] RD_MID_BEG = 7'h20;
   localparam logic [6:0] RD_MID_END = 7'h24;
   localparam logic [6:0] RD_HI = 7'h30;
   // read-enable control bit location
   localparam logic [6:0] READ_CTRL_ADDR = 7'h0e;
   localparam int unsigned READ_CTRL_BIT = 0;
   // fixed i2c slave address
   localparam logic [6:0] SLAVE_ADDR = 7'h12;
   // 3-wire frame bit counts
   localparam logic [4:0] TW_ADDR_DONE = 5'h08;
   localparam logic [4:0] TW_LAST_BIT = 5'h0f;
   localparam logic [4:0] TW_FRAME_END = 5'h10;
   // i2c bit counts
   localparam logic [3:0] I2C_BYTE_END = 4'h8;
   localparam logic [3:0] I2C_LAST_TX = 4'h7;
   // byte kinds on the i2c side
   localparam logic [1:0] K_DEV = 2'h0;
   localparam logic [1:0] K_REG = 2'h1;
   localparam logic [1:0] K_DATA = 2'h2;
   // synchroniser lanes
   localparam int unsigned SY_N = 5;
   localparam int unsigned SY_SEL = 0;
   localparam int unsigned SY_PDN = 1;
   localparam int unsigned SY_SCL = 2;
   localparam int unsigned SY_SDA = 3;
   localparam int unsigned SY_TOG = 4;
   // link timing, host-side limits
   localparam int unsigned SYS_PERIOD_NS = 100;
   localparam int unsigned TW_MIN_PERIOD_NS = 200;
   localparam int unsigned I2C_MIN_PERIOD_NS = 2500;
   localparam int unsigned I2C_MIN_PERIOD_CYC =
      I2C_MIN_PERIOD_NS / SYS_PERIOD_NS;

   // true where a read returns real contents
   function automatic logic addr_readable(input logic [6:0] a);
      return (a <= RD_LO_END) || (a == RD_HI) ||
         ((a >= RD_MID_BEG) && (a <= RD_MID_END));
   endfunction

   // address counter step with wrap past the last register
   function automatic logic [6:0] addr_next(input logic [6:0] a);
      return (a >= ADDR_LAST) ? ADDR_FIRST : 7'(a + 7'h01);
   endfunction
endpackage
`default_nettype wire

// *** pin_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // asynchronous input
   input wire logic d_i,
   // filtered level and its edges
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic s1_q; // metastable stage, read only by s2_q
   logic s2_q;
   logic s3_q;
   logic lvl_q; // accepted level

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign level_o = lvl_q;
   assign rise_o = (s2_q == s3_q) && s3_q && !lvl_q;
   assign fall_o = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule // pin_sync3
`default_nettype wire

// *** three_wire_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module three_wire_link (
   // link clock and resets
   input wire logic control_clock_i,
   input wire logic frame_rst_n_i,
   input wire logic rstn_i,
   // data pin
   input wire logic control_data_i,
   output logic control_data_o,
   output logic control_data_oe_o,
   // register read port (quasi-static source)
   output logic [6:0] rd_addr_o,
   input wire logic [7:0] rd_data_i,
   input wire logic read_en_i,
   // write hand-off to the system domain
   output logic wr_toggle_o,
   output logic [6:0] wr_addr_o,
   output logic [7:0] wr_data_o
);
   logic [4:0] cnt_q; // rising edges seen in this frame
   logic [14:0] sh_q; // direction, address, data
   logic [7:0] out_q; // read data shifter
   logic dir_q; // direction bit of this frame, held for checks
   logic drive_q; // pin driven
   logic tog_q;
   logic [6:0] wa_q;
   logic [7:0] wd_q;

   ////////////////////////////////////////////////////////////////////
   // frame capture; chip select high clears the frame at once, so a
   // short frame leaves no trace
   always_ff @(posedge control_clock_i or negedge frame_rst_n_i) begin
      if (!frame_rst_n_i) begin
         cnt_q <= 5'h00;
         sh_q <= 15'h0000;
         dir_q <= 1'b0;
      end else begin
         // first bit of the frame is the direction
         if (cnt_q == 5'h00) begin
            dir_q <= control_data_i;
         end
         if (cnt_q != codec_ctl_pkg::TW_FRAME_END) begin
            cnt_q <= 5'(cnt_q + 5'h01);
         end
         sh_q <= {sh_q[13:0], control_data_i};
      end
   end

   // commit on the 16th rising edge; held until the next commit, the
   // system side samples these words after the toggle settles
   always_ff @(posedge control_clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tog_q <= 1'b0;
         wa_q <= 7'h00;
         wd_q <= 8'h00;
      end else if ((cnt_q == codec_ctl_pkg::TW_LAST_BIT) && sh_q[14]) begin
         tog_q <= ~tog_q;
         wa_q <= sh_q[13:7];
         wd_q <= {sh_q[6:0], control_data_i};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read launch at the falling edge of the 8th clock, shift after
   always_ff @(negedge control_clock_i or negedge frame_rst_n_i) begin
      if (!frame_rst_n_i) begin
         out_q <= 8'h00;
         drive_q <= 1'b0; // released as chip select rises
      end else if (cnt_q == codec_ctl_pkg::TW_ADDR_DONE) begin
         out_q <= rd_data_i;
         drive_q <= !sh_q[7] && read_en_i;
      end else begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   assign rd_addr_o = sh_q[6:0];
   assign control_data_o = out_q[7];
   assign control_data_oe_o = drive_q;
   assign wr_toggle_o = tog_q;
   assign wr_addr_o = wa_q;
   assign wr_data_o = wd_q;

   ////////////////////////////////////////////////////////////////////
   a_commit_edge: assert property (
      @(posedge control_clock_i) disable iff (!frame_rst_n_i)
      (cnt_q == 5'h0f) && sh_q[14] |=> (wr_toggle_o != $past(tog_q)))
      else $error("write not committed on 16th edge");
   a_read_launch: assert property (
      @(posedge control_clock_i) disable iff (!frame_rst_n_i)
      (cnt_q == 5'h08) && !dir_q && read_en_i |->
      control_data_oe_o && (control_data_o == rd_data_i[7]))
      else $error("read data not launched on 8th falling edge");
   a_read_gated: assert property (
      @(negedge control_clock_i) disable iff (!frame_rst_n_i)
      (cnt_q == 5'h08) && (sh_q[7] || !read_en_i) |=>
      !control_data_oe_o)
      else $error("data pin driven without read enable");
   a_drive_window: assert property (
      @(posedge control_clock_i) disable iff (!frame_rst_n_i)
      control_data_oe_o |-> (cnt_q >= 5'h08) && !dir_q)
      else $error("data pin driven outside read data phase");
   c_read_frame: cover property (
      @(negedge control_clock_i) disable iff (!frame_rst_n_i)
      control_data_oe_o);
endmodule // three_wire_link
`default_nettype wire

// *** codec_control_serial_port.sv ***
// What this block does
// - strap low selects 3-wire, high selects i2c
// - 3-wire frame: direction, 7-bit address, 8 data
// - sample on rising clock, launch on falling
// - write commits on the 16th rising edge
// - read drives from 8th falling edge to select
// - read data driven only when read bit set
// - data pin released except during read data
// - power-down low restores all register values
// - only listed addresses read back real contents
// - i2c slave runs fast mode up to 400 kHz
// - answer only slave address 0010010, then direction
// - write: register address byte, then data bytes
// - acknowledge every received byte in i2c mode, except a foreign slave address
// - counter steps after each write, wraps past 4fh
// - master acknowledge fetches next address, wraps
// - current read sends counter address, nack stops
`timescale 1ns/1ps
`default_nettype none
module codec_control_serial_port (
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // strap and power-down pins
   input wire logic interface_sel_i,
   input wire logic power_down_n_i,
   // clock pin: 3-wire link clock, i2c scl
   input wire logic control_clock_i,
   // select pin: 3-wire chip select, i2c sda
   input wire logic chip_select_n_i,
   output logic sda_o,
   output logic sda_oe_o,
   // 3-wire data pin
   input wire logic control_data_i,
   output logic control_data_o,
   output logic control_data_oe_o,
   // register contents for the codec core
   output logic [639:0] regs_o,
   output logic i2c_mode_o
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, // waiting for start
      ST_RECV = 5'h02, // shifting in a byte
      ST_ACK = 5'h04, // driving our acknowledge
      ST_SEND = 5'h08, // shifting out a byte
      ST_MACK = 5'h10 // master acknowledge slot
   } i2c_state_e;

   logic [7:0] regs_q [0:codec_ctl_pkg::REG_COUNT-1]; // control registers
   logic [codec_ctl_pkg::SY_N-1:0] sy_raw; // pins and the write toggle into synchronisers
   logic [codec_ctl_pkg::SY_N-1:0] sy_lvl;
   logic [codec_ctl_pkg::SY_N-1:0] sy_rise;
   logic [codec_ctl_pkg::SY_N-1:0] sy_fall;
   logic i2c_mode; // strap after filtering
   logic pdn_ok; // power-down released
   logic scl_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic i2c_start;
   logic i2c_stop;
   logic link_rst_n; // 3-wire frame reset
   logic link_tog;
   logic [6:0] link_rd_addr;
   logic [7:0] link_rd_data;
   logic [6:0] link_wa;
   logic [7:0] link_wd;
   logic tw_commit; // 3-wire write lands in system domain
   logic read_en;
   i2c_state_e st_q;
   logic [3:0] bit_q; // bits in the current byte
   logic [7:0] sh_q; // received byte
   logic [7:0] tx_q; // byte being sent
   logic [1:0] kind_q; // what the next received byte means
   logic rw_q; // direction from the address byte
   logic [6:0] ptr_q; // address counter
   logic sda_oe_q;
   logic [7:0] i2c_rd_data;
   logic byte_done; // 8th bit in, scl falling
   logic i2c_wr; // data byte write strobe

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   assign sy_raw[codec_ctl_pkg::SY_SEL] = interface_sel_i;
   assign sy_raw[codec_ctl_pkg::SY_PDN] = power_down_n_i;
   assign sy_raw[codec_ctl_pkg::SY_SCL] = control_clock_i;
   assign sy_raw[codec_ctl_pkg::SY_SDA] = chip_select_n_i;
   assign sy_raw[codec_ctl_pkg::SY_TOG] = link_tog;

   // one synchroniser lane per pin except the 3-wire data pin, plus one for the write toggle
   generate
      for (genvar g = 0; g < codec_ctl_pkg::SY_N; g++) begin : g_sync
         pin_sync3 u_sync (
            .clk_i(clk_sys_i),
            .rstn_i(rstn_i),
            .d_i(sy_raw[g]),
            .level_o(sy_lvl[g]),
            .rise_o(sy_rise[g]),
            .fall_o(sy_fall[g])
         );
      end
   endgenerate

   assign i2c_mode = sy_lvl[codec_ctl_pkg::SY_SEL];
   assign pdn_ok = sy_lvl[codec_ctl_pkg::SY_PDN];
   assign scl_lvl = sy_lvl[codec_ctl_pkg::SY_SCL];
   assign scl_rise = sy_rise[codec_ctl_pkg::SY_SCL];
   assign scl_fall = sy_fall[codec_ctl_pkg::SY_SCL];
   assign sda_lvl = sy_lvl[codec_ctl_pkg::SY_SDA];
   // start and stop: data edge while the clock is high
   assign i2c_start = sy_fall[codec_ctl_pkg::SY_SDA] && scl_lvl;
   assign i2c_stop = sy_rise[codec_ctl_pkg::SY_SDA] && scl_lvl;

   ////////////////////////////////////////////////////////////////////
   // 3-wire engine on the link clock; the frame is held in reset while
   // chip select is high, in i2c mode or in power-down
   assign link_rst_n = rstn_i && power_down_n_i && !chip_select_n_i &&
      !interface_sel_i;
   assign read_en =
      regs_q[codec_ctl_pkg::READ_CTRL_ADDR][codec_ctl_pkg::READ_CTRL_BIT];
   // registers only change on a host write, a power-down clear or a reset, none of which
   // can overlap the read frame that samples them, so the byte is stable when taken
   assign link_rd_data = codec_ctl_pkg::addr_readable(link_rd_addr) ?
      regs_q[link_rd_addr] : codec_ctl_pkg::UNDEF_READ_VAL;

   three_wire_link u_link (
      .control_clock_i(control_clock_i),
      .frame_rst_n_i(link_rst_n),
      .rstn_i(rstn_i),
      .control_data_i(control_data_i),
      .control_data_o(control_data_o),
      .control_data_oe_o(control_data_oe_o),
      .rd_addr_o(link_rd_addr),
      .rd_data_i(link_rd_data),
      .read_en_i(read_en),
      .wr_toggle_o(link_tog),
      .wr_addr_o(link_wa),
      .wr_data_o(link_wd)
   );

   // toggle edge marks a committed write; words were stable for long
   assign tw_commit = (sy_rise[codec_ctl_pkg::SY_TOG] ||
      sy_fall[codec_ctl_pkg::SY_TOG]) && !i2c_mode;

   ////////////////////////////////////////////////////////////////////
   // i2c read byte and write strobe
   assign i2c_rd_data = codec_ctl_pkg::addr_readable(ptr_q) ?
      regs_q[ptr_q] : codec_ctl_pkg::UNDEF_READ_VAL;
   assign byte_done = (st_q == ST_RECV) && scl_fall &&
      (bit_q == codec_ctl_pkg::I2C_BYTE_END) && !i2c_start && !i2c_stop;
   assign i2c_wr = i2c_mode && pdn_ok && byte_done &&
      (kind_q == codec_ctl_pkg::K_DATA);

   ////////////////////////////////////////////////////////////////////
   // register file; power-down restores every value
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < codec_ctl_pkg::REG_COUNT; i++) begin
            regs_q[i] <= codec_ctl_pkg::REG_RESET_VAL;
         end
      end else if (!pdn_ok) begin
         for (int i = 0; i < codec_ctl_pkg::REG_COUNT; i++) begin
            regs_q[i] <= codec_ctl_pkg::REG_RESET_VAL;
         end
      end else if (i2c_wr && (ptr_q <= codec_ctl_pkg::ADDR_LAST)) begin
         regs_q[ptr_q] <= sh_q;
      end else if (tw_commit &&
         (link_wa <= codec_ctl_pkg::ADDR_LAST)) begin
         regs_q[link_wa] <= link_wd;
      end
   end

   // flat copy for the codec core
   generate
      for (genvar r = 0; r < codec_ctl_pkg::REG_COUNT; r++) begin : g_out
         assign regs_o[r*8 +: 8] = regs_q[r];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // i2c slave; start and stop override any state
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         kind_q <= codec_ctl_pkg::K_DEV;
         rw_q <= 1'b0;
         ptr_q <= codec_ctl_pkg::ADDR_FIRST;
         sda_oe_q <= 1'b0;
      end else if (!i2c_mode || !pdn_ok) begin
         // 3-wire mode or power-down: bus idle, counter cleared
         st_q <= ST_IDLE;
         sda_oe_q <= 1'b0;
         ptr_q <= codec_ctl_pkg::ADDR_FIRST;
      end else if (i2c_start) begin
         // also a repeated start for random reads
         st_q <= ST_RECV;
         bit_q <= 4'h0;
         kind_q <= codec_ctl_pkg::K_DEV;
         sda_oe_q <= 1'b0;
      end else if (i2c_stop) begin
         st_q <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (st_q)
            ST_RECV: begin
               // shift in msb first on the clock rising edge
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_lvl};
                  bit_q <= 4'(bit_q + 4'h1);
               end
               if (byte_done) begin
                  if ((kind_q == codec_ctl_pkg::K_DEV) &&
                     (sh_q[7:1] != codec_ctl_pkg::SLAVE_ADDR)) begin
                     st_q <= ST_IDLE; // not ours
                  end else begin
                     st_q <= ST_ACK;
                     sda_oe_q <= 1'b1;
                     if (kind_q == codec_ctl_pkg::K_DEV) begin
                        rw_q <= sh_q[0];
                     end else if (kind_q == codec_ctl_pkg::K_REG) begin
                        ptr_q <= sh_q[6:0]; // top bit ignored
                     end else begin
                        ptr_q <= codec_ctl_pkg::addr_next(ptr_q);
                     end
                  end
               end
            end
            ST_ACK: begin
               // master clocks the acknowledge
               if (scl_fall) begin
                  bit_q <= 4'h0;
                  if ((kind_q == codec_ctl_pkg::K_DEV) && rw_q) begin
                     // read: send the counter's register
                     st_q <= ST_SEND;
                     tx_q <= i2c_rd_data;
                     sda_oe_q <= !i2c_rd_data[7];
                     ptr_q <= codec_ctl_pkg::addr_next(ptr_q);
                  end else begin
                     st_q <= ST_RECV;
                     sda_oe_q <= 1'b0;
                     kind_q <= (kind_q == codec_ctl_pkg::K_DEV) ?
                        codec_ctl_pkg::K_REG : codec_ctl_pkg::K_DATA;
                  end
               end
            end
            ST_SEND: begin
               // open drain: drive only the zero bits
               if (scl_fall) begin
                  bit_q <= 4'(bit_q + 4'h1);
                  if (bit_q == codec_ctl_pkg::I2C_LAST_TX) begin
                     st_q <= ST_MACK;
                     sda_oe_q <= 1'b0;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sda_oe_q <= !tx_q[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise && sda_lvl) begin
                  st_q <= ST_IDLE; // no acknowledge: stop sending
               end else if (scl_fall) begin
                  // acknowledged: next address, wraps
                  st_q <= ST_SEND;
                  bit_q <= 4'h0;
                  tx_q <= i2c_rd_data;
                  sda_oe_q <= !i2c_rd_data[7];
                  ptr_q <= codec_ctl_pkg::addr_next(ptr_q);
               end
            end
            ST_IDLE: begin
               sda_oe_q <= 1'b0;
            end
            default: begin
               st_q <= ST_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_q;
   assign i2c_mode_o = i2c_mode;

   ////////////////////////////////////////////////////////////////////
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   a_mode_quiet: assert property (
      !i2c_mode |=> !sda_oe_o)
      else $error("i2c data driven in 3-wire mode");
   a_pdn_clear: assert property (
      !pdn_ok |=> (regs_q[7'h0e] == 8'h00) && (regs_q[7'h00] == 8'h00))
      else $error("registers not cleared in power-down");
   a_addr_ack: assert property (
      i2c_mode && pdn_ok && byte_done && (kind_q == 2'h0) &&
      (sh_q[7:1] == 7'h12) |=> sda_oe_o && (st_q == ST_ACK))
      else $error("matching slave address not acknowledged");
   a_addr_ignore: assert property (
      i2c_mode && byte_done && (kind_q == 2'h0) &&
      (sh_q[7:1] != 7'h12) |=> !sda_oe_o [*2])
      else $error("foreign slave address acknowledged");
   a_data_ack: assert property (
      i2c_wr |=> sda_oe_o && (st_q == ST_ACK))
      else $error("data byte not acknowledged");
   a_write_land: assert property (
      i2c_wr && (ptr_q < 7'h4f) |=>
      (regs_q[$past(ptr_q)] == $past(sh_q)) && (ptr_q == $past(ptr_q) + 1))
      else $error("i2c write lost or counter not stepped");
   a_write_wrap: assert property (
      i2c_wr && (ptr_q == 7'h4f) |=> (ptr_q == 7'h00))
      else $error("write counter did not wrap");
   a_read_wrap: assert property (
      (st_q == ST_MACK) && scl_fall && !i2c_start && !i2c_stop &&
      i2c_mode && pdn_ok && (ptr_q == 7'h4f) |=> (ptr_q == 7'h00) &&
      (st_q == ST_SEND))
      else $error("read counter did not wrap");
   a_nack_stop: assert property (
      (st_q == ST_MACK) && scl_rise && sda_lvl && i2c_mode && pdn_ok &&
      !i2c_start && !i2c_stop |=> (st_q == ST_IDLE) && !sda_oe_o)
      else $error("transmission continued after no acknowledge");
   a_undef_read: assert property (
      !codec_ctl_pkg::addr_readable(ptr_q) && (st_q == ST_ACK) && rw_q &&
      scl_fall && i2c_mode && pdn_ok && !i2c_start && !i2c_stop
      |=> (tx_q == 8'h00))
      else $error("unreadable address returned contents");

   c_i2c_write: cover property (i2c_wr);
   c_i2c_read_more: cover property ((st_q == ST_MACK) && scl_fall);
   c_tw_write: cover property (tw_commit);
endmodule // codec_control_serial_port
`default_nettype wire

// *** tw_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module tw_host (
   // link pins toward the device
   output logic control_clock_o,
   output logic chip_select_n_o,
   output logic data_o,
   // device side of the data pin
   input wire logic dev_data_i,
   input wire logic dev_oe_i,
   // device pull-down on the shared i2c data line
   input wire logic dev_sda_oe_i
);
   logic cs_q; // host level on the select / i2c data pin
   logic drv_q; // host owns the pin
   logic val_q; // host bit value
   logic oe_seen; // device drove in this frame
   // resolved pin level; released pin shows the inverse, never a stale bit
   assign data_o = dev_oe_i ? dev_data_i : (drv_q ? val_q : ~val_q);
   // open drain: pulled up unless either side pulls low
   assign chip_select_n_o = cs_q && !dev_sda_oe_i;
   initial begin
      control_clock_o = 1'b0;
      cs_q = 1'b1;
      drv_q = 1'b0;
      val_q = 1'b0;
      oe_seen = 1'b0;
   end
   // any drive by the device is remembered
   always @(posedge dev_oe_i) oe_seen = 1'b1;
   // i2c bit: data set with clock low, sampled late in the high phase
   task automatic i2c_bit(input logic b, output logic r);
      cs_q = b;
      #625 control_clock_o = 1'b1; // 400 kHz at most
      #1250 r = chip_select_n_o;
      control_clock_o = 1'b0;
      #625;
   endtask
   // start when first is 1, stop otherwise
   task automatic i2c_cond(input logic first);
      cs_q = first;
      #625 control_clock_o = 1'b1;
      #625 cs_q = !first;
      #625 control_clock_o = 1'b0;
      #625;
   endtask
   // byte out msb first, then the acknowledge slot with level m
   task automatic i2c_byte(input logic [7:0] b, input logic m,
      output logic [7:0] r, output logic a);
      logic x;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         i2c_bit(b[7 - i], x);
         r = {r[6:0], x};
      end
      i2c_bit(m, a); // clocked by us, released only when m is 1
   endtask
   // one frame; clock stands still outside it
   task automatic frame(input logic w, input logic [6:0] a,
      input logic [7:0] d, input int n, output logic [7:0] q,
      output logic s);
      logic [15:0] sh;
      sh = {w, a, d};
      q = 8'h00;
      oe_seen = 1'b0;
      drv_q = 1'b1;
      cs_q = 1'b0;
      for (int i = 0; i < n; i++) begin
         val_q = sh[15 - i]; // msb first
         if (i >= 8 && !w) drv_q = 1'b0; // turn the pin round for reads
         #62.5 control_clock_o = 1'b1; // sample edge
         if (i >= 8) q = {q[6:0], data_o};
         #62.5 control_clock_o = 1'b0;
      end
      s = oe_seen;
      #62.5 cs_q = 1'b1; // close every frame
      drv_q = 1'b0;
      #1000;
   endtask
endmodule // tw_host
`default_nettype wire

// *** test_codec_control_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_codec_control_serial_port;
   logic clk_sys_i = 1'b0; // 10 MHz system clock
   logic rstn_i = 1'b0;
   logic interface_sel_i = 1'b0;
   logic power_down_n_i = 1'b1;
   wire control_clock;
   wire chip_select_n;
   wire pin;
   logic dq;
   logic doe;
   logic soe;
   logic [639:0] regs;
   logic mode;
   logic [7:0] rd;
   logic seen;
   int miscompares = 0;
   int checks = 0;
   // rows: address in the upper byte, data in the lower
   logic [15:0] rows [4] = '{16'h0155, 16'h0faa, 16'h4f81, 16'h3c7e};
   always #50 clk_sys_i = ~clk_sys_i;
   codec_control_serial_port dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .interface_sel_i(interface_sel_i), .power_down_n_i(power_down_n_i),
      .control_clock_i(control_clock), .chip_select_n_i(chip_select_n), .sda_o(), .sda_oe_o(soe),
      .control_data_i(pin), .control_data_o(dq), .control_data_oe_o(doe),
      .regs_o(regs), .i2c_mode_o(mode));
   tw_host host (.control_clock_o(control_clock), .chip_select_n_o(chip_select_n),
      .data_o(pin), .dev_data_i(dq), .dev_oe_i(doe), .dev_sda_oe_i(soe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // write frame, then allow the 3..4 cycle crossing
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
      host.frame(1'b1, a, d, n, rd, seen);
      repeat (8) @(posedge clk_sys_i);
   endtask
   task automatic rg(input logic [6:0] a, input logic [7:0] e);
      chk(regs[8 * int'(a) +: 8], e);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (12) @(posedge clk_sys_i);
      chk({7'h00, |regs}, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][14:8], rows[i][7:0], 16);
         rg(rows[i][14:8], rows[i][7:0]);
         chk({7'h00, seen}, 8'h00);
      end
      $display("table test done");
      host.frame(1'b0, 7'h01, 8'h00, 16, rd, seen);
      chk({7'h00, seen}, 8'h00);
      wr(codec_ctl_pkg::READ_CTRL_ADDR, 8'h01, 16);
      host.frame(1'b0, 7'h01, 8'h00, 16, rd, seen);
      chk(rd, 8'h55);
      chk({7'h00, seen}, 8'h01);
      wr(7'h12, 8'hff, 16);
      host.frame(1'b0, 7'h12, 8'h00, 16, rd, seen);
      chk(rd, codec_ctl_pkg::UNDEF_READ_VAL);
      $display("read test done");
      wr(7'h01, 8'h33, 15);
      rg(7'h01, 8'h55);
      $display("short frame test done");
      power_down_n_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      chk({7'h00, |regs}, 8'h00);
      power_down_n_i <= 1'b1;
      interface_sel_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      chk({7'h00, mode}, 8'h01);
      wr(7'h01, 8'h77, 16);
      rg(7'h01, 8'h00);
      $display("power and strap test done");
      // multi-byte write across the wrap point
      host.i2c_cond(1'b1);
      host.i2c_byte(8'h24, 1'b1, rd, seen);
      chk({7'h00, seen}, 8'h00);
      host.i2c_byte(8'h4f, 1'b1, rd, seen);
      chk({7'h00, seen}, 8'h00);
      for (int i = 1; i < 4; i++) begin
         host.i2c_byte(8'(17 * i), 1'b1, rd, seen);
         chk({7'h00, seen}, 8'h00);
      end
      host.i2c_cond(1'b0);
      repeat (8) @(posedge clk_sys_i);
      rg(7'h4f, 8'h11);
      rg(7'h00, 8'h22);
      rg(7'h01, 8'h33);
      // random read of the last register, then wrap to the first
      host.i2c_cond(1'b1);
      host.i2c_byte(8'h24, 1'b1, rd, seen);
      host.i2c_byte(8'h4f, 1'b1, rd, seen);
      host.i2c_cond(1'b1); // repeated start
      host.i2c_byte(8'h25, 1'b1, rd, seen);
      chk({7'h00, seen}, 8'h00);
      host.i2c_byte(8'hff, 1'b0, rd, seen);
      chk(rd, codec_ctl_pkg::UNDEF_READ_VAL);
      host.i2c_byte(8'hff, 1'b1, rd, seen);
      chk(rd, 8'h22);
      host.i2c_cond(1'b0);
      // foreign address gets no acknowledge
      host.i2c_cond(1'b1);
      host.i2c_byte(8'h30, 1'b1, rd, seen);
      chk({7'h00, seen}, 8'h01);
      host.i2c_cond(1'b0);
      // current address read continues after the last one sent
      host.i2c_cond(1'b1);
      host.i2c_byte(8'h25, 1'b1, rd, seen);
      host.i2c_byte(8'hff, 1'b1, rd, seen);
      chk(rd, 8'h33);
      host.i2c_cond(1'b0);
      $display("i2c test done");
      results();
   end
endmodule // test_codec_control_serial_port
`default_nettype wire
